/* hw/erf_consts.svh */
`ifndef ERF_CONSTS_SVH
`define ERF_CONSTS_SVH

// ==========================================================
// filter control word layout
`define ERF_BIT_HASH 15
`define ERF_BIT_CRC 6
`define ERF_BIT_SHORT 4
`define ERF_BIT_LOCAL 3
`define ERF_BIT_FOREIGN 2
`define ERF_BIT_MCAST 1
`define ERF_BIT_BCAST 0
`define ERF_CTRL_RESET 16'h0059
// bits outside this mask are not implemented and read as zero
`define ERF_CTRL_MASK 16'h805F

// ==========================================================
// frame geometry
`define ERF_MIN_FRAME_BYTES 16'h0040
`define ERF_DEST_BYTES 16'h0006
`define ERF_LEN_MAX 16'hFFFF

// ==========================================================
// crc-32, generator 04C11DB7 processed lsb first (reflected form)
`define ERF_CRC_POLY 32'h04C11DB7
`define ERF_CRC_POLY_REFL 32'hEDB88320
`define ERF_CRC_INIT 32'hFFFFFFFF
`define ERF_CRC_RESIDUE 32'hDEBB20E3
`define ERF_HASH_PTR_MSB 28
`define ERF_HASH_PTR_LSB 23

`endif

/* hw/erf_pkg.sv */
package erf_pkg;

  // ==========================================================
  // stream carriers
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } erf_rx_byte_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } erf_buf_byte_t;

  typedef struct packed {
    logic local_hit;
    logic foreign_hit;
    logic mcast_hit;
    logic bcast_hit;
    logic hash_hit;
  } erf_addr_flags_t;

  typedef enum logic [3:0] {
    ERF_WHY_NONE = 4'h0,
    ERF_WHY_CRC_BAD = 4'h1,
    ERF_WHY_SHORT = 4'h2,
    ERF_WHY_LOCAL = 4'h3,
    ERF_WHY_FOREIGN = 4'h4,
    ERF_WHY_MCAST = 4'h5,
    ERF_WHY_BCAST = 4'h6,
    ERF_WHY_HASH = 4'h7,
    ERF_WHY_NO_MATCH = 4'h8
  } erf_reason_t;

  typedef struct packed {
    logic valid;
    logic accept;
    erf_reason_t reason;
    logic truncated;
  } erf_verdict_t;

  typedef enum logic [2:0] {
    ERF_ST_IDLE = 3'b001,
    ERF_ST_RECV = 3'b010,
    ERF_ST_SKIP = 3'b100
  } erf_state_t;

endpackage

/* hw/erf_crc_byte.sv */
`timescale 1ns/100ps
`default_nettype none
`include "erf_consts.svh"

// one byte of ethernet crc-32, lsb of the byte first
module erf_crc_byte (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);

  always_comb begin
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[0] ^ data[i]) begin
        crc_out = (crc_out >> 1) ^ `ERF_CRC_POLY_REFL;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/erf_addr_class.sv */
`timescale 1ns/100ps
`default_nettype none
`include "erf_consts.svh"

// classifies a captured destination address; first wire byte sits in [47:40]
module erf_addr_class (
  input wire logic [47:0] dest_addr,
  input wire logic [47:0] station_address,
  input wire logic [31:0] dest_crc,
  input wire logic [63:0] hash_table,
  output erf_pkg::erf_addr_flags_t flags
);

  // ==========================================================
  // hash pointer: crc in msb-first order, bits 28..23
  function automatic logic [5:0] hash_ptr(input logic [31:0] refl_crc);
    logic [31:0] norm;
    norm = '0;
    for (int i = 0; i < 32; i++) begin
      norm[i] = refl_crc[31 - i];
    end
    return norm[`ERF_HASH_PTR_MSB:`ERF_HASH_PTR_LSB];
  endfunction

  logic [5:0] ptr;
  logic [15:0] hash_word;
  logic is_group;

  assign ptr = hash_ptr(dest_crc);
  // upper pointer bits pick the word, lower four pick the bit
  assign hash_word = hash_table[{ptr[5:4], 4'h0} +: 16];
  assign is_group = dest_addr[40];

  always_comb begin
    flags.local_hit = (dest_addr == station_address);
    flags.foreign_hit = !is_group && (dest_addr != station_address);
    flags.mcast_hit = is_group;
    flags.bcast_hit = (dest_addr == 48'hFFFFFFFFFFFF);
    flags.hash_hit = hash_word[ptr[3:0]];
  end

endmodule
`default_nettype wire

/* hw/erf_rx_filter.sv */
// How it works
// - enabled, bad crc frames discarded, good passed
// - bytes beyond maximum length truncated
// - crc reject enable, bit 6, resets on
// - crc reject off passes every frame
// - enabled, frames under 64 bytes discarded
// - short reject enable, bit 4, resets on
// - local unicast accepts exact station address
// - local unicast enable, bit 3, resets on
// - foreign unicast accepts other unicast destinations
// - foreign unicast enable, bit 2, resets off
// - multicast accepts destination group bit set
// - multicast enable, bit 1, resets off
// - broadcast accepts all-ones destination
// - broadcast enable, bit 0, resets on
// - crc over destination, bits 28..23 pointer
// - pointer selects table bit; set accepts
// - hash enable, bit 15, resets off
// - first deciding filter in priority wins
// - frames nobody accepts are discarded
`timescale 1ns/100ps
`default_nettype none
`include "erf_consts.svh"

module erf_rx_filter (
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_receive_enable,
  input wire logic ctrl_write,
  input wire logic [15:0] rx_filter_control_word,
  input wire logic [47:0] station_address,
  input wire logic [15:0] max_frame_length_limit,
  input wire logic [15:0] hash_table_word_0,
  input wire logic [15:0] hash_table_word_1,
  input wire logic [15:0] hash_table_word_2,
  input wire logic [15:0] hash_table_word_3,
  input wire erf_pkg::erf_rx_byte_t rx_in,
  output logic [15:0] filter_control_readback,
  output erf_pkg::erf_buf_byte_t buf_out,
  output erf_pkg::erf_verdict_t verdict,
  output logic busy
);

  // ==========================================================
  // helpers
  function automatic logic ctl_bit(input logic [15:0] word, input int pos);
    return word[pos];
  endfunction

  // ==========================================================
  // declarations
  erf_pkg::erf_state_t state_reg;
  erf_pkg::erf_state_t state_next;
  logic [15:0] ctrl_reg;
  logic [15:0] frame_ctrl_reg;
  logic [15:0] frame_ctrl_now;
  logic [15:0] len_reg;
  logic [15:0] len_base;
  logic [15:0] len_next;
  logic [31:0] crc_reg;
  logic [31:0] crc_base;
  logic [31:0] crc_next;
  logic [47:0] dest_reg;
  logic [31:0] dest_crc_reg;
  logic dest_done_reg;
  logic trunc_reg;
  logic trunc_next;
  logic in_idle;
  logic byte_in;
  logic starting;
  logic receiving;
  logic keep_byte;
  logic frame_end;
  logic crc_good;
  logic too_short;
  logic addr_ok;
  logic [63:0] hash_table;
  erf_pkg::erf_addr_flags_t flags;
  erf_pkg::erf_verdict_t verdict_next;

  assign in_idle = (state_reg == erf_pkg::ERF_ST_IDLE);
  assign byte_in = rx_in.valid;
  assign starting = in_idle && byte_in && frame_receive_enable;
  assign receiving = starting || (state_reg == erf_pkg::ERF_ST_RECV && byte_in);
  assign frame_end = receiving && rx_in.last;
  assign hash_table = {hash_table_word_3, hash_table_word_2,
                       hash_table_word_1, hash_table_word_0};

  // ==========================================================
  // filter control word
  // writes land in the live word at once; the chain itself uses a copy taken at frame
  // start, so a write mid-frame cannot split one frame's decision across two settings
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg <= `ERF_CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= rx_filter_control_word & `ERF_CTRL_MASK;
    end
  end

  assign filter_control_readback = ctrl_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      frame_ctrl_reg <= `ERF_CTRL_RESET;
    end else if (starting) begin
      frame_ctrl_reg <= ctrl_reg;
    end
  end

  assign frame_ctrl_now = starting ? ctrl_reg : frame_ctrl_reg;

  // ==========================================================
  // frame sequencing
  // a frame that begins while reception is off is skipped whole, never half-taken
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      erf_pkg::ERF_ST_IDLE: begin
        if (byte_in && !rx_in.last) begin
          state_next = frame_receive_enable ? erf_pkg::ERF_ST_RECV : erf_pkg::ERF_ST_SKIP;
        end
      end
      erf_pkg::ERF_ST_RECV: begin
        if (byte_in && rx_in.last) begin
          state_next = erf_pkg::ERF_ST_IDLE;
        end
      end
      erf_pkg::ERF_ST_SKIP: begin
        if (byte_in && rx_in.last) begin
          state_next = erf_pkg::ERF_ST_IDLE;
        end
      end
      default: begin
        state_next = erf_pkg::ERF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= erf_pkg::ERF_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_next != erf_pkg::ERF_ST_IDLE);
    end
  end

  // ==========================================================
  // length count and truncation
  // bytes past the limit are neither stored nor fed to the crc, so the
  // stored frame loses its trailing check sequence and almost always fails crc
  assign len_base = in_idle ? 16'h0000 : len_reg;
  assign keep_byte = receiving && (len_base < max_frame_length_limit);
  assign len_next = (keep_byte && len_base != `ERF_LEN_MAX) ? len_base + 16'h0001 : len_base;
  assign trunc_next = (in_idle ? 1'b0 : trunc_reg) || (receiving && !keep_byte);

  always_ff @(posedge clock) begin
    if (srst) begin
      len_reg <= 16'h0000;
    end else if (receiving) begin
      len_reg <= len_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      trunc_reg <= 1'b0;
    end else if (receiving) begin
      trunc_reg <= trunc_next;
    end
  end

  // ==========================================================
  // running crc over the kept bytes
  assign crc_base = in_idle ? `ERF_CRC_INIT : crc_reg;

  erf_crc_byte u_crc (
    .crc_in(crc_base),
    .data(rx_in.data),
    .crc_out(crc_next)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      crc_reg <= `ERF_CRC_INIT;
    end else if (keep_byte) begin
      crc_reg <= crc_next;
    end else if (starting) begin
      crc_reg <= `ERF_CRC_INIT;
    end
  end

  // a frame with an intact check sequence leaves the fixed residue behind
  assign crc_good = keep_byte ? (crc_next == `ERF_CRC_RESIDUE)
                              : (crc_base == `ERF_CRC_RESIDUE);

  // ==========================================================
  // destination capture and hash crc
  always_ff @(posedge clock) begin
    if (srst) begin
      dest_reg <= 48'h000000000000;
    end else if (keep_byte && len_base < `ERF_DEST_BYTES) begin
      dest_reg <= {dest_reg[39:0], rx_in.data};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dest_crc_reg <= `ERF_CRC_INIT;
    end else if (keep_byte && len_base == `ERF_DEST_BYTES - 16'h0001) begin
      dest_crc_reg <= crc_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dest_done_reg <= 1'b0;
    end else if (starting) begin
      dest_done_reg <= 1'b0;
    end else if (keep_byte && len_base == `ERF_DEST_BYTES - 16'h0001) begin
      dest_done_reg <= 1'b1;
    end
  end

  // address filters only see a frame whose destination was complete before its last byte
  assign addr_ok = dest_done_reg && !in_idle;

  erf_addr_class u_addr (
    .dest_addr(dest_reg),
    .station_address(station_address),
    .dest_crc(dest_crc_reg),
    .hash_table(hash_table),
    .flags(flags)
  );

  // ==========================================================
  // decision chain, highest priority first
  assign too_short = (len_next < `ERF_MIN_FRAME_BYTES);

  always_comb begin
    verdict_next.valid = frame_end;
    verdict_next.truncated = trunc_next;
    verdict_next.accept = 1'b0;
    verdict_next.reason = erf_pkg::ERF_WHY_NO_MATCH;
    if (ctl_bit(frame_ctrl_now, `ERF_BIT_CRC) && !crc_good) begin
      verdict_next.reason = erf_pkg::ERF_WHY_CRC_BAD;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_SHORT) && too_short) begin
      verdict_next.reason = erf_pkg::ERF_WHY_SHORT;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_LOCAL) && addr_ok
                 && flags.local_hit) begin
      verdict_next.accept = 1'b1;
      verdict_next.reason = erf_pkg::ERF_WHY_LOCAL;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_FOREIGN) && addr_ok
                 && flags.foreign_hit) begin
      verdict_next.accept = 1'b1;
      verdict_next.reason = erf_pkg::ERF_WHY_FOREIGN;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_MCAST) && addr_ok
                 && flags.mcast_hit) begin
      verdict_next.accept = 1'b1;
      verdict_next.reason = erf_pkg::ERF_WHY_MCAST;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_BCAST) && addr_ok
                 && flags.bcast_hit) begin
      verdict_next.accept = 1'b1;
      verdict_next.reason = erf_pkg::ERF_WHY_BCAST;
    end else if (ctl_bit(frame_ctrl_now, `ERF_BIT_HASH) && addr_ok
                 && flags.hash_hit) begin
      verdict_next.accept = 1'b1;
      verdict_next.reason = erf_pkg::ERF_WHY_HASH;
    end
    if (!frame_end) begin
      verdict_next.accept = 1'b0;
      verdict_next.reason = erf_pkg::ERF_WHY_NONE;
      verdict_next.truncated = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      verdict <= '0;
    end else begin
      verdict <= verdict_next;
    end
  end

  // ==========================================================
  // byte stream to the packet buffer
  // bytes go out as they arrive, the last byte of an untruncated frame in the same cycle as the verdict; the buffer keeps or rewinds on the verdict,
  // which avoids holding a whole frame here
  always_ff @(posedge clock) begin
    if (srst) begin
      buf_out <= '0;
    end else begin
      buf_out.valid <= keep_byte;
      buf_out.first <= starting;
      buf_out.data <= keep_byte ? rx_in.data : 8'h00;
    end
  end

endmodule
`default_nettype wire

/* tb/erf_mac_src.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// receive path model: one byte a cycle, no back-pressure
module erf_mac_src (
  input wire logic clock,
  output var erf_pkg::erf_rx_byte_t rx_in
);
  initial begin
    rx_in = '0;
  end

  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      @(posedge clock);
      rx_in <= '{valid: 1'b1, last: (i == q.size() - 1), data: q[i]};
    end
  endtask

  // idle data is the inverse of the last byte so a stale byte never looks current
  task automatic idle();
    @(posedge clock);
    rx_in <= '{valid: 1'b0, last: 1'b0, data: ~rx_in.data};
  endtask
endmodule

`default_nettype wire

/* tb/erf_rx_filter_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "erf_consts.svh"

module erf_rx_filter_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_receive_enable,
  input wire logic ctrl_write,
  input wire logic [15:0] rx_filter_control_word,
  input wire logic [15:0] max_frame_length_limit,
  input wire erf_pkg::erf_rx_byte_t rx_in,
  input wire logic [15:0] filter_control_readback,
  input wire erf_pkg::erf_buf_byte_t buf_out,
  input wire erf_pkg::erf_verdict_t verdict,
  input wire logic busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ==========================================================
  // bytes handed on in the current frame
  logic [15:0] kept_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      kept_reg <= 16'h0000;
    end else if (buf_out.valid) begin
      kept_reg <= buf_out.first ? 16'h0001 : kept_reg + 16'h0001;
    end
  end

  sequence s_last_taken;
    rx_in.valid && rx_in.last;
  endsequence

  sequence s_verdict_out;
    verdict.valid;
  endsequence

  // ==========================================================
  // assertions
  verdict_after_last_a: assert property (s_verdict_out |-> $past(rx_in.valid && rx_in.last))
    else $error("verdict without a preceding last byte");
  verdict_idle_zero_a: assert property (!verdict.valid |-> verdict[5:0] == 6'h00)
    else $error("verdict fields set while not valid");
  accept_reason_a: assert property (s_verdict_out |-> verdict.accept ==
      (verdict.reason inside {[erf_pkg::ERF_WHY_LOCAL:erf_pkg::ERF_WHY_HASH]}))
    else $error("accept flag disagrees with reason");
  ctrl_reset_a: assert property (disable iff (1'b0) srst |=>
      filter_control_readback == `ERF_CTRL_RESET)
    else $error("control word reset value wrong");
  ctrl_load_a: assert property (ctrl_write |=>
      filter_control_readback == ($past(rx_filter_control_word) & `ERF_CTRL_MASK))
    else $error("control word not loaded");
  ctrl_hold_a: assert property (!ctrl_write |=> $stable(filter_control_readback))
    else $error("control word changed without a write");
  busy_end_a: assert property (s_last_taken |=> !busy)
    else $error("busy still high after last byte");
  kept_limit_a: assert property (kept_reg <= max_frame_length_limit)
    else $error("more bytes kept than the length limit");
  buf_cause_a: assert property (buf_out.valid |-> $past(rx_in.valid))
    else $error("buffer byte without an input byte");
endmodule

bind erf_rx_filter erf_rx_filter_checker chk (.clock(clock), .srst(srst),
  .frame_receive_enable(frame_receive_enable), .ctrl_write(ctrl_write),
  .rx_filter_control_word(rx_filter_control_word), .max_frame_length_limit(max_frame_length_limit),
  .rx_in(rx_in), .filter_control_readback(filter_control_readback), .buf_out(buf_out),
  .verdict(verdict), .busy(busy));

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "erf_consts.svh"

module tb;
  typedef logic [7:0] erf_bytes_t[$];
  typedef struct {
    logic [15:0] cfg;
    logic [47:0] dest;
    int len;
    logic bad;
    logic [15:0] htf;
    logic [15:0] ht3;
    logic acc;
    logic [3:0] why;
  } erf_case_t;

  localparam logic [47:0] STA = 48'h0211_2233_4455;
  localparam logic [47:0] FR = 48'h0211_2233_4466;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  // hashes to pointer 34h: word 3, bit 4
  localparam logic [47:0] HD = 48'h0100_0000_012C;

  erf_case_t tc[17] = '{
    '{16'h0059, STA, 64, 0, 0, 0, 1, 3},
    '{16'h0059, STA, 64, 1, 0, 0, 0, 1},
    '{16'h0059, STA, 63, 0, 0, 0, 0, 2},
    '{16'h0059, BC, 64, 0, 0, 0, 1, 6},
    '{16'h0059, FR, 64, 0, 0, 0, 0, 8},
    '{16'h0059, MC, 64, 0, 0, 0, 0, 8},
    '{16'h0019, STA, 64, 1, 0, 0, 1, 3},
    '{16'h0049, STA, 63, 0, 0, 0, 1, 3},
    '{16'h0051, STA, 64, 0, 0, 0, 0, 8},
    '{16'h0054, FR, 64, 0, 0, 0, 1, 4},
    '{16'h0054, MC, 64, 0, 0, 0, 0, 8},
    '{16'h0052, MC, 64, 0, 0, 0, 1, 5},
    '{16'h0058, BC, 64, 0, 0, 0, 0, 8},
    '{16'h8050, HD, 64, 0, 0, 16'h0010, 1, 7},
    '{16'h8050, HD, 64, 0, 16'hFFFF, 16'hFFEF, 0, 8},
    '{16'h0050, HD, 64, 0, 16'hFFFF, 16'hFFFF, 0, 8},
    '{16'h8052, HD, 64, 0, 0, 16'h0010, 1, 5}
  };

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic rx_en = 1'b1;
  logic ctrl_write = 1'b0;
  logic [15:0] ctrl_word = 16'h0000;
  logic [15:0] max_len = 16'h0600;
  logic [63:0] ht = 64'h0;
  logic [15:0] readback;
  erf_pkg::erf_rx_byte_t rx_in;
  erf_pkg::erf_buf_byte_t buf_out;
  erf_pkg::erf_verdict_t verdict;
  logic busy;
  erf_pkg::erf_verdict_t vq[$];
  int nbuf = 0;
  logic [7:0] first_byte = 8'h00;
  int bad_count = 0;
  int compares = 0;

  erf_mac_src p (.clock(clock), .rx_in(rx_in));
  erf_rx_filter uut (.clock(clock), .srst(srst), .frame_receive_enable(rx_en),
    .ctrl_write(ctrl_write), .rx_filter_control_word(ctrl_word), .station_address(STA),
    .max_frame_length_limit(max_len), .hash_table_word_0(ht[15:0]),
    .hash_table_word_1(ht[31:16]), .hash_table_word_2(ht[47:32]),
    .hash_table_word_3(ht[63:48]), .rx_in(rx_in), .filter_control_readback(readback),
    .buf_out(buf_out), .verdict(verdict), .busy(busy));

  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (verdict.valid === 1'b1) vq.push_back(verdict);
    if (buf_out.valid === 1'b1) nbuf++;
    if (buf_out.valid === 1'b1 && buf_out.first === 1'b1) first_byte <= buf_out.data;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] r;
    r = `ERF_CRC_INIT;
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) r = (r >> 1) ^ ((r[0] ^ q[i][b]) ? `ERF_CRC_POLY_REFL : 32'h0);
    end
    return r;
  endfunction

  function automatic erf_bytes_t build(input logic [47:0] d, input int n, input logic bad);
    erf_bytes_t q;
    logic [31:0] f;
    for (int i = 0; i < n - 4; i++) q.push_back(i < 6 ? d[47 - 8 * i -: 8] : 8'(i));
    f = ~crc_of(q);
    for (int i = 0; i < 4; i++) q.push_back(f[8 * i +: 8]);
    if (bad) q[n - 1] = ~q[n - 1];
    return q;
  endfunction

  // reception is stopped while filters change, so no frame sees a half-written setup
  task automatic setup(input logic [15:0] w, input logic [15:0] hf, input logic [15:0] h3,
      input logic [15:0] ml);
    @(posedge clock);
    rx_en <= 1'b0;
    ctrl_write <= 1'b1;
    ctrl_word <= w;
    ht <= {h3, hf, hf, hf};
    max_len <= ml;
    @(posedge clock);
    ctrl_write <= 1'b0;
    rx_en <= 1'b1;
    nbuf = 0;
  endtask

  task automatic frame(input erf_bytes_t q);
    p.send(q);
    p.idle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    erf_pkg::erf_verdict_t v;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(readback, 16'h0059);
    setup(16'hFFFF, 16'h0, 16'h0, 16'h0600);
    #1;
    check(readback, 16'h805F);
    foreach (tc[i]) begin
      setup(tc[i].cfg, tc[i].htf, tc[i].ht3, 16'h0600);
      frame(build(tc[i].dest, tc[i].len, tc[i].bad));
      check(readback, tc[i].cfg);
      check(vq.size(), 1);
      v = vq.pop_front();
      check(v.accept, tc[i].acc);
      check(v.reason, tc[i].why);
      check(nbuf, tc[i].len);
      check(first_byte, tc[i].dest[47:40]);
      check(busy, 1'b0);
    end
    setup(16'h0059, 16'h0, 16'h0, 16'd70);
    frame(build(STA, 80, 0));
    check(vq.size(), 1);
    v = vq.pop_front();
    check(v.reason, erf_pkg::ERF_WHY_CRC_BAD);
    check(v.truncated, 1'b1);
    check(nbuf, 70);
    setup(16'h0059, 16'h0, 16'h0, 16'h0600);
    p.send(build(BC, 64, 0));
    frame(build(FR, 64, 0));
    check(vq.size(), 2);
    v = vq.pop_front();
    check(v.reason, erf_pkg::ERF_WHY_BCAST);
    v = vq.pop_front();
    check({v.accept, v.reason}, {1'b0, erf_pkg::ERF_WHY_NO_MATCH});
    check(nbuf, 128);
    check(first_byte, 8'h02);
    // a frame that begins with reception off is skipped whole
    nbuf = 0;
    @(posedge clock);
    rx_en <= 1'b0;
    frame(build(STA, 64, 0));
    check(vq.size(), 0);
    check(nbuf, 0);
    check(busy, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
